// ===== inc/tmrc_pkg.sv
package tmrc_pkg;
  // Register byte addresses on APB (one aligned word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h04;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_COMPARE = 8'h10;
  localparam logic [7:0] ADDR_CMP_MODE = 8'h14;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h18;
  // Control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CS_BIT = 1;
  localparam int CTRL_NOSYNC_BIT = 2;
  localparam int CTRL_OSCEN_BIT = 3;
  localparam int CTRL_PS_LSB = 4;
  localparam int CTRL_SYSRUN_BIT = 6;
  localparam int CTRL_WIDE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  // Flag register fields
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_IE_BIT = 1;
  // Compare channel mode that fires the special event trigger
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [1:0] DIR_RESET = 2'h3;
  localparam logic [7:0] HBUF_RESET = 8'h00;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // Instruction cycle is four system clocks
  localparam int INSTR_DIV = 4;
endpackage

// ===== rtl/tmrc_edge_detect.sv
module tmrc_edge_detect (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sync_en,
  input wire logic din,
  output logic rise
);
  logic meta_q, sync_q, prev_q;
  logic meta_d, sync_d, prev_d, src;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
    // Bypass takes the raw level, two cycles earlier but glitch prone
    src = sync_en ? sync_q : din;
    prev_d = src;
    rise = src & ~prev_q;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
endmodule

// ===== rtl/tmrc_prescaler.sv
module tmrc_prescaler (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick_in,
  input wire logic [1:0] ratio_sel,
  input wire logic clear,
  output logic tick_out
);
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] limit;

  always_comb begin
    limit = 3'((4'h1 << ratio_sel) - 4'h1);
    cnt_d = cnt_q;
    tick_out = 1'b0;
    if (clear) begin
      cnt_d = 3'h0;
    end else if (tick_in) begin
      if (cnt_q >= limit) begin
        cnt_d = 3'h0;
        tick_out = 1'b1;
      end else begin
        cnt_d = 3'(cnt_q + 3'h1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ===== rtl/tmrc_timer.sv
// What this block does
// - Counter counts up and wraps to zero
// - Wrap sets flag; enable gates interrupt
// - Run bit zero stops counting
// - Source zero counts instruction cycles
// - Source one counts external rising edges
// - Oscillator enable bit drives crystal
// - Enabled crystal forces pins input, reads zero
// - Status bit shows system clock source
// - Crystal keeps running in power modes
// - Special trigger clears counter, starts conversion
// - Special trigger never sets overflow flag
// - Counter write beats trigger reset
// - Compare value acts as period
// - Wide mode: low read latches high
// - Wide mode: low write loads high
// - Low write clears prescaler; high doesn't
//
// Our own choices: the APB slave port and the placing of the registers.
module tmrc_timer (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin,
  input wire logic crystal_in_pin,
  input wire logic crystal_clk,
  input wire logic sysclk_from_crystal,
  input wire logic adc_enabled,
  input wire logic [1:0] osc_pin_level,
  output logic crystal_osc_enable,
  output logic [1:0] osc_pin_oe,
  output logic [1:0] osc_pin_read,
  output logic overflow_irq,
  output logic adc_start,
  output logic [15:0] count_value
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] hbuf_q, hbuf_d;
  logic ovf_q, ovf_d;
  logic ie_q, ie_d;
  logic [15:0] cmp_q, cmp_d;
  logic [3:0] mode_q, mode_d;
  logic [1:0] dir_q, dir_d;
  logic [1:0] div_q, div_d;
  logic [31:0] rdata_q, rdata_d;
  logic adc_q, adc_d;
  logic wr, rd, lane0, bad_addr;
  logic run, ext_sel, nosync, oscen, wide;
  logic [1:0] ps_sel;
  logic ext_src, ext_rise, int_tick, in_tick, cnt_tick;
  logic wr_low, wr_high, rd_low, special_hit;

  assign run = ctrl_q[tmrc_pkg::CTRL_RUN_BIT];
  assign ext_sel = ctrl_q[tmrc_pkg::CTRL_CS_BIT];
  assign nosync = ctrl_q[tmrc_pkg::CTRL_NOSYNC_BIT];
  assign oscen = ctrl_q[tmrc_pkg::CTRL_OSCEN_BIT];
  assign wide = ctrl_q[tmrc_pkg::CTRL_WIDE_BIT];
  assign ps_sel = ctrl_q[tmrc_pkg::CTRL_PS_LSB +: 2];

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign lane0 = pstrb[0];
  always_comb begin
    case (paddr)
      tmrc_pkg::ADDR_CTRL, tmrc_pkg::ADDR_CNT_LOW, tmrc_pkg::ADDR_CNT_HIGH, tmrc_pkg::ADDR_FLAGS,
      tmrc_pkg::ADDR_COMPARE, tmrc_pkg::ADDR_CMP_MODE, tmrc_pkg::ADDR_PIN_DIR: bad_addr = 1'b0;
      default: bad_addr = 1'b1;
    endcase
  end
  assign pslverr = psel & penable & bad_addr;
  assign prdata = rdata_q;

  assign wr_low = wr & lane0 & (paddr == tmrc_pkg::ADDR_CNT_LOW);
  assign wr_high = wr & lane0 & (paddr == tmrc_pkg::ADDR_CNT_HIGH);
  assign rd_low = rd & (paddr == tmrc_pkg::ADDR_CNT_LOW);

  assign ext_src = oscen ? crystal_clk : ext_clock_pin;

  tmrc_edge_detect u_edge (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sync_en(~nosync),
    .din(ext_src),
    .rise(ext_rise)
  );

  always_comb begin
    div_d = 2'(div_q + 2'h1);
    int_tick = (div_q == 2'(tmrc_pkg::INSTR_DIV - 1));
  end

  assign in_tick = run & (ext_sel ? ext_rise : int_tick);

  tmrc_prescaler u_pre (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick_in(in_tick),
    .ratio_sel(ps_sel),
    .clear(wr_low),
    .tick_out(cnt_tick)
  );

  // async mode trigger not guaranteed; logic still applies it
  assign special_hit = (mode_q == tmrc_pkg::CMP_MODE_SPECIAL) & (cnt_q == cmp_q);

  // Settings group: control, enable, compare, mode, direction
  always_comb begin
    ctrl_d = ctrl_q;
    ie_d = ie_q;
    cmp_d = cmp_q;
    mode_d = mode_q;
    dir_d = dir_q;
    // Status bit is not writable; it mirrors the clock switch
    // clock status
    ctrl_d[tmrc_pkg::CTRL_SYSRUN_BIT] = sysclk_from_crystal;
    // Byte-wide registers need lane 0; other lanes are ignored
    if (wr && lane0) begin
      case (paddr)
        tmrc_pkg::ADDR_CTRL: begin
          ctrl_d = (pwdata[7:0] & tmrc_pkg::CTRL_WMASK) | (ctrl_d & ~tmrc_pkg::CTRL_WMASK);
        end
        tmrc_pkg::ADDR_FLAGS: begin
          ie_d = pwdata[tmrc_pkg::FLAG_IE_BIT];
        end
        tmrc_pkg::ADDR_CMP_MODE: begin
          mode_d = pwdata[3:0];
        end
        tmrc_pkg::ADDR_PIN_DIR: begin
          dir_d = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    if (wr && (paddr == tmrc_pkg::ADDR_COMPARE)) begin
      if (pstrb[0]) begin
        cmp_d[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        cmp_d[15:8] = pwdata[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= tmrc_pkg::CTRL_RESET;
      ie_q <= 1'b0;
      cmp_q <= tmrc_pkg::CMP_RESET;
      mode_q <= tmrc_pkg::MODE_RESET;
      dir_q <= tmrc_pkg::DIR_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      ie_q <= ie_d;
      cmp_q <= cmp_d;
      mode_q <= mode_d;
      dir_q <= dir_d;
    end
  end

  // Counter group: live count and high-byte buffer
  always_comb begin
    cnt_d = cnt_q;
    hbuf_d = hbuf_q;
    if (cnt_tick) begin
      cnt_d = 16'(cnt_q + 16'h1);
    end
    // Level match: a stopped count sitting on the compare value stays at zero
    // trigger clears silently
    if (special_hit) begin
      cnt_d = tmrc_pkg::CNT_RESET;
    end
    if (wr_low) begin
      cnt_d[7:0] = pwdata[7:0];
      if (wide) begin
        cnt_d[15:8] = hbuf_q;
      end
    end
    if (wr_high) begin
      if (wide) begin
        hbuf_d = pwdata[7:0];
      end else begin
        cnt_d[15:8] = pwdata[7:0];
      end
    end
    if (rd_low && wide) begin
      hbuf_d = cnt_q[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= tmrc_pkg::CNT_RESET;
      hbuf_q <= tmrc_pkg::HBUF_RESET;
    end else begin
      cnt_q <= cnt_d;
      hbuf_q <= hbuf_d;
    end
  end

  // Flag group: sticky overflow
  always_comb begin
    ovf_d = ovf_q;
    // Set wins over a same-cycle clear, so a clear write never hides an overflow
    // sticky flag, set wins over clear
    if (wr && lane0 && (paddr == tmrc_pkg::ADDR_FLAGS) && !pwdata[tmrc_pkg::FLAG_OVF_BIT]) begin
      ovf_d = 1'b0;
    end
    // A counter write in the wrap cycle blocks the flag, even a wide high write that leaves the count wrapped
    // overflow sets flag
    if (cnt_tick && (cnt_q == tmrc_pkg::CNT_MAX) && !special_hit && !wr_low && !wr_high) begin
      ovf_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // Read group: read data shows in the cycle after the access
  always_comb begin
    adc_d = special_hit & adc_enabled;
    rdata_d = rdata_q;
    // Holes read as zero; pslverr flags them in the same access
    if (rd) begin
      rdata_d = 32'h0;
      case (paddr)
        tmrc_pkg::ADDR_CTRL: rdata_d[7:0] = ctrl_q;
        tmrc_pkg::ADDR_CNT_LOW: rdata_d[7:0] = cnt_q[7:0];
        tmrc_pkg::ADDR_CNT_HIGH: rdata_d[7:0] = wide ? hbuf_q : cnt_q[15:8];
        tmrc_pkg::ADDR_FLAGS: rdata_d[1:0] = {ie_q, ovf_q};
        tmrc_pkg::ADDR_COMPARE: rdata_d[15:0] = cmp_q;
        tmrc_pkg::ADDR_CMP_MODE: rdata_d[3:0] = mode_q;
        tmrc_pkg::ADDR_PIN_DIR: rdata_d[1:0] = dir_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0;
      adc_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      adc_q <= adc_d;
    end
  end

  // Divider runs free, so stopping the count never shifts the instruction phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // no power-mode gating here, so it keeps running
  assign crystal_osc_enable = oscen;
  // pins forced to input
  // Direction bit one means input, as on a port tristate latch
  assign osc_pin_oe = oscen ? 2'b00 : ~dir_q;
  assign osc_pin_read = oscen ? 2'b00 : osc_pin_level;
  assign overflow_irq = ovf_q & ie_q;
  assign adc_start = adc_q;
  assign count_value = cnt_q;
endmodule

// ===== test/tmrc_asserts.sv
module tmrc_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sysclk_from_crystal,
  input wire logic adc_enabled,
  input wire logic crystal_osc_enable,
  input wire logic [1:0] osc_pin_oe,
  input wire logic [1:0] osc_pin_read,
  input wire logic adc_start,
  input wire logic [15:0] count_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_q;
  // Writes move the count freely, so the step right after one is not judged
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= psel && penable && pwrite;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_bad;
    s_acc ##0 (paddr > 8'h18 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_ctl;
    s_acc ##0 (paddr == tmrc_pkg::ADDR_CTRL);
  endsequence
  AST_STEP: assert property (count_value != $past(count_value) && count_value != 16'h0 && !wr_q
    |-> count_value == $past(count_value) + 16'h1) else $error("count jumped");
  AST_OSC_EN: assert property (s_ctl ##0 pwrite |=> crystal_osc_enable == $past(pwdata[3]))
    else $error("osc enable wrong");
  AST_PIN_IN: assert property (crystal_osc_enable |-> osc_pin_oe == 2'h0 && osc_pin_read == 2'h0)
    else $error("osc pins driven");
  AST_STATUS: assert property (s_ctl ##0 !pwrite && $stable(sysclk_from_crystal)
    |=> prdata[6] == $past(sysclk_from_crystal)) else $error("status bit wrong");
  AST_ADC_EN: assert property (adc_start |-> $past(adc_enabled))
    else $error("conversion while off");
  AST_ADC_ZERO: assert property (adc_start && !wr_q |-> count_value == 16'h0)
    else $error("trigger kept count");
  AST_ERR: assert property (s_bad |-> pslverr) else $error("no error on hole");
  AST_RD0: assert property (s_bad ##0 !pwrite |=> prdata == 32'h0) else $error("hole read data");
endmodule
bind tmrc_timer tmrc_asserts tmrc_asserts_inst (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .sysclk_from_crystal, .adc_enabled, .crystal_osc_enable, .osc_pin_oe,
  .osc_pin_read, .adc_start, .count_value);

// ===== test/tmrc_far_model.sv
module tmrc_far_model (
  input wire logic ref_clk,
  input wire logic ext_on,
  input wire logic osc_on,
  output logic ext_clock_pin,
  output logic crystal_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int ne = 0;
  int nc = 0;
  // Pin period 6 cycles, crystal 10; both stand low while off
  always @(posedge ref_clk) begin
    ne <= ext_on ? (ne + 1) % 6 : 0;
    nc <= osc_on ? (nc + 1) % 10 : 0;
    ext_clock_pin <= ext_on && ne >= 3;
    crystal_clk <= osc_on && nc >= 5;
  end
  initial begin
    ext_clock_pin = 1'b0;
    crystal_clk = 1'b0;
  end
endmodule

// ===== test/tb_sixteen_bit_timer_counter.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("mismatch %0t got %h want %h", $time, g, e); end end
module tb_sixteen_bit_timer_counter;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CT = tmrc_pkg::ADDR_CTRL;
  localparam logic [7:0] LO = tmrc_pkg::ADDR_CNT_LOW;
  localparam logic [7:0] HI = tmrc_pkg::ADDR_CNT_HIGH;
  localparam logic [7:0] FL = tmrc_pkg::ADDR_FLAGS;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, sysclk, adc_en;
  logic ext_on, ext, xtal, oscen, irq, adc_start, rd_pend;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, d, e, exp_rd;
  logic [31:0] expq[$];
  logic [1:0] oe, pin_rd;
  logic [15:0] cnt, m;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  tmrc_timer tmrc_timer_inst (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .ext_clock_pin(ext), .crystal_in_pin(1'b0), .crystal_clk(xtal),
    .sysclk_from_crystal(sysclk), .adc_enabled(adc_en), .osc_pin_level(2'h3), .crystal_osc_enable(oscen),
    .osc_pin_oe(oe), .osc_pin_read(pin_rd), .overflow_irq(irq), .adc_start, .count_value(cnt));
  tmrc_far_model tmrc_far_model_inst (.ref_clk, .ext_on, .osc_on(oscen), .ext_clock_pin(ext), .crystal_clk(xtal));
  always #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    expq.push_back(v);
    apb(1'b0, a, 32'h0);
  endtask
  // Skip two edges so a mode switch never bends the measured gap
  task automatic gap(input int x);
    logic [15:0] v;
    repeat (2) @(cnt);
    @(negedge ref_clk);
    v = cnt;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cnt === v && n < 300);
    `CHK(n, x)
  endtask
  always @(posedge ref_clk) begin
    if (rd_pend) begin
      exp_rd = expq.pop_front();
      `CHK(prdata, exp_rd)
    end
    rd_pend = psel && penable && !pwrite;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    {ref_clk, arst_n, psel, penable, pwrite, sysclk, adc_en, ext_on, rd_pend} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 32'h21b3;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(CT, 32'h0);
    rd(tmrc_pkg::ADDR_COMPARE, 32'hffff);
    rd(8'h1c, 32'h0);
    d = xs() & 32'hff;
    e = xs() & 32'hff;
    wr(LO, d);
    wr(HI, e);
    rd(LO, d);
    rd(HI, e);
    wr(CT, 32'h80);
    wr(HI, 32'h9a);
    wr(LO, 32'hbc);
    wr(HI, 32'h11);
    rd(LO, 32'hbc);
    rd(HI, 32'h9a);
    for (int p = 0; p < 4; p++) begin
      wr(CT, 32'h81 | (p << 4));
      gap(4 << p);
    end
    wr(CT, 32'h80);
    @(negedge ref_clk);
    m = cnt;
    repeat (40) @(negedge ref_clk);
    `CHK(cnt, m)
    ext_on <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(CT, 32'h83 | (s << 2));
      gap(6);
    end
    ext_on <= 1'b0;
    wr(tmrc_pkg::ADDR_PIN_DIR, 32'h0);
    @(negedge ref_clk);
    `CHK(oe, 2'h3)
    `CHK(pin_rd, 2'h3)
    wr(CT, 32'hcb);
    gap(10);
    `CHK(pin_rd, 2'h0)
    `CHK(oe, 2'h0)
    rd(CT, 32'h8b);
    sysclk <= 1'b1;
    rd(CT, 32'hcb);
    sysclk <= 1'b0;
    wr(CT, 32'h80);
    wr(HI, 32'h0);
    wr(LO, 32'h0);
    wr(tmrc_pkg::ADDR_COMPARE, 32'h5);
    wr(tmrc_pkg::ADDR_CMP_MODE, 32'hb);
    adc_en <= 1'b1;
    // Trigger used with the internal clock only
    wr(CT, 32'h81);
    m = 16'h0;
    n = 0;
    repeat (100) begin
      @(negedge ref_clk);
      if (cnt > m) m = cnt;
      if (adc_start === 1'b1) n++;
    end
    `CHK(m, 16'h5)
    `CHK(n > 3, 1'b1)
    wr(CT, 32'h80);
    rd(FL, 32'h0);
    wr(tmrc_pkg::ADDR_COMPARE, 32'h0);
    wr(LO, 32'h0);
    wr(LO, 32'h22);
    rd(LO, 32'h22);
    wr(tmrc_pkg::ADDR_CMP_MODE, 32'h0);
    wr(HI, 32'hff);
    wr(LO, 32'hfd);
    wr(FL, 32'h2);
    wr(CT, 32'h81);
    repeat (40) @(negedge ref_clk);
    `CHK(irq, 1'b1)
    wr(CT, 32'h80);
    wr(FL, 32'h1);
    rd(FL, 32'h1);
    `CHK(irq, 1'b0)
    wr(FL, 32'h0);
    rd(FL, 32'h0);
    // Let the watcher compare the last read before the verdict
    repeat (2) @(posedge ref_clk);
    complete_run();
  end
endmodule
